// >>> core/blscr_pkg.sv
// Package: register map, field layout and carrier types of the blit/line setup and clip registers
package blscr_pkg;

   // Bus geometry
   localparam int          ADR_W = 12;
   localparam int          DAT_W = 32;

   // Register byte offsets
   localparam logic [11:0] CMD_OFS    = 12'h200;
   localparam logic [11:0] DEST_OFS   = 12'h208;
   localparam logic [11:0] SRC_OFS    = 12'h20c;
   localparam logic [11:0] CMP_OFS    = 12'h210;
   localparam logic [11:0] CLIPUL_OFS = 12'h214;
   localparam logic [11:0] CLIPLR_OFS = 12'h218;

   // Writable bits; reserved bits are not stored and read as zero
   localparam logic [31:0] CMD_MASK    = 32'h88000003;
   localparam logic [31:0] DEST_MASK   = 32'hffffffff;
   localparam logic [31:0] SRC_MASK    = 32'h1fffffff;
   localparam logic [31:0] CMP_MASK    = 32'h0000ffff;
   localparam logic [31:0] CLIP_MASK   = 32'h03ff07ff;
   localparam logic [31:0] REG_RST     = 32'h00000000;

   // Command bits
   localparam int          CMD_LINE_BIT    = 0;
   localparam int          CMD_BPP16_BIT   = 1;
   localparam int          CMD_AUTOGO_BIT  = 27;
   localparam int          CMD_CMPDST_BIT  = 31;

   // Coordinate and offset fields
   localparam int          X_LSB     = 0;
   localparam int          X_MSB     = 11;
   localparam int          Y_LSB     = 16;
   localparam int          Y_MSB     = 27;
   localparam int          HOFS_LSB  = 13;
   localparam int          HOFS_MSB  = 15;
   localparam int          OCT_LSB   = 29;
   localparam int          OCT_MSB   = 31;
   localparam int          DLT_LSB   = 12;
   localparam int          DLT_MSB   = 28;
   localparam int          FRAC_W    = 4;
   localparam int          COLOR_MSB = 15;
   localparam int          BYTE_MSB  = 7;
   localparam int          CLIPX_MSB = 10;
   localparam int          CLIPY_LSB = 16;
   localparam int          CLIPY_MSB = 25;

   // Block-transfer view of the origin registers
   typedef struct packed {
      logic [2:0]  rowOfs;
      logic [11:0] destY;
      logic [2:0]  pixOfs;
      logic [11:0] destX;
      logic [11:0] srcY;
      logic [11:0] srcX;
   } blscr_blit_t;

   // Line-draw view of the origin registers
   typedef struct packed {
      logic [2:0]  octant;
      logic        yMajor;
      logic        negX;
      logic        negY;
      logic [11:0] startX;
      logic [11:0] startY;
      logic [12:0] majorInt;
      logic [3:0]  majorFrac;
      logic [12:0] minorInt;
      logic [3:0]  minorFrac;
   } blscr_line_t;

   // Clip rectangle
   typedef struct packed {
      logic [10:0] left;
      logic [9:0]  top;
      logic [10:0] right;
      logic [9:0]  bottom;
   } blscr_clip_t;

endpackage

// >>> core/blscr_regs.sv
// Module: drawing-engine setup registers on a classic Wishbone slave, with clip and colour checks
//
// Function
// - Blit dest origin: X 11:0, Y 27:16
// - Bits 15:13 give pattern start pixel 0-7
// - Bits 31:29 give pattern start row 0-7
// - Line: start X 11:0, major delta 28:12
// - Bits 31:29 octant: major axis and directions
// - Blit source origin: X 11:0, Y 27:16
// - Line: start Y 11:0, minor delta 28:12
// - Low four delta bits are fraction bits
// - Compare colour 15:0 against chosen pixel
// - Suppress pixels left of left clip
// - Suppress pixels above top clip
// - Suppress pixels beyond right or bottom clip
// - Dest origin write starts command when enabled
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module blscr_regs (
   input  wire logic                   clock,
   input  wire logic                   nrst,
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [blscr_pkg::ADR_W-1:0] adr_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic [blscr_pkg::DAT_W-1:0] dat_i,
   output logic [blscr_pkg::DAT_W-1:0] dat_o,
   output logic                        ack_o,
   input  wire logic                   pixValid,
   input  wire logic [11:0]            pixX,
   input  wire logic [11:0]            pixY,
   input  wire logic [15:0]            srcColor,
   input  wire logic [15:0]            dstColor,
   output logic                        pixWrite,
   output logic                        pixTransparent,
   output logic                        lineMode,
   output blscr_pkg::blscr_blit_t      blitSetup,
   output blscr_pkg::blscr_line_t      lineSetup,
   output blscr_pkg::blscr_clip_t      clipSetup,
   output logic                        startPulse
);
   import blscr_pkg::*;

   logic        rstMeta;
   logic        rstN;
   logic [31:0] cmdReg;
   logic [31:0] destReg;
   logic [31:0] srcReg;
   logic [31:0] cmpReg;
   logic [31:0] clipUlReg;
   logic [31:0] clipLrReg;
   logic        busReq;
   logic        busWr;
   logic        hitDest;
   logic [31:0] next_dat;
   logic        insideClip;
   logic        colorMatch;
   logic [15:0] cmpPixel;

   // Byte-lane merge of bus write data, reserved bits forced to zero
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res & mask;
   endfunction

   // Octant code to major axis and step directions
   function automatic logic [2:0] octDecode(input logic [2:0] oct);
      return {oct[0] ^ oct[1], oct[1] ^ oct[2], oct[2]};
   endfunction

   // Reset release through two flops so deassertion is clean
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstN    <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN    <= rstMeta;
      end
   end

   // Request seen for the first time; ack drops the cycle after it is given
   assign busReq  = cyc_i && stb_i && !ack_o;
   assign busWr   = busReq && we_i;
   assign hitDest = busWr && (adr_i == DEST_OFS);

   // Single-wait-state acknowledge, also for unmapped addresses
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= busReq;
      end
   end

   // Register writes take effect in the same edge that raises ack
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         cmdReg    <= REG_RST;
         destReg   <= REG_RST;
         srcReg    <= REG_RST;
         cmpReg    <= REG_RST;
         clipUlReg <= REG_RST;
         clipLrReg <= REG_RST;
      end else if (busWr) begin
         unique case (adr_i)
            CMD_OFS: begin
               cmdReg <= merge(cmdReg, dat_i, sel_i, CMD_MASK);
            end
            DEST_OFS: begin
               destReg <= merge(destReg, dat_i, sel_i, DEST_MASK);
            end
            SRC_OFS: begin
               srcReg <= merge(srcReg, dat_i, sel_i, SRC_MASK);
            end
            CMP_OFS: begin
               cmpReg <= merge(cmpReg, dat_i, sel_i, CMP_MASK);
            end
            CLIPUL_OFS: begin
               clipUlReg <= merge(clipUlReg, dat_i, sel_i, CLIP_MASK);
            end
            CLIPLR_OFS: begin
               clipLrReg <= merge(clipLrReg, dat_i, sel_i, CLIP_MASK);
            end
            default: begin
               cmdReg <= cmdReg; // Unmapped writes are acked and dropped
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      unique case (adr_i)
         CMD_OFS:    next_dat = cmdReg;
         DEST_OFS:   next_dat = destReg;
         SRC_OFS:    next_dat = srcReg;
         CMP_OFS:    next_dat = cmpReg;
         CLIPUL_OFS: next_dat = clipUlReg;
         CLIPLR_OFS: next_dat = clipLrReg;
         default:    next_dat = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         dat_o <= 32'h00000000;
      end else if (busReq && !we_i) begin
         dat_o <= next_dat;
      end
   end

   // Command kick: one pulse per dest origin write when auto-start is set
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         startPulse <= 1'b0;
      end else begin
         startPulse <= hitDest && cmdReg[CMD_AUTOGO_BIT];
      end
   end

   // Layout views; the unused view is held at zero so the datapath cannot mix them
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         lineMode  <= 1'b0;
         blitSetup <= '0;
         lineSetup <= '0;
      end else begin
         lineMode <= cmdReg[CMD_LINE_BIT];
         if (cmdReg[CMD_LINE_BIT]) begin
            blitSetup <= '0;
            lineSetup.octant    <= destReg[OCT_MSB:OCT_LSB];
            {lineSetup.yMajor, lineSetup.negX, lineSetup.negY} <=
               octDecode(destReg[OCT_MSB:OCT_LSB]);
            lineSetup.startX    <= destReg[X_MSB:X_LSB];
            lineSetup.startY    <= srcReg[X_MSB:X_LSB];
            lineSetup.majorInt  <= destReg[DLT_MSB:DLT_LSB+FRAC_W];
            lineSetup.majorFrac <= destReg[DLT_LSB+FRAC_W-1:DLT_LSB];
            lineSetup.minorInt  <= srcReg[DLT_MSB:DLT_LSB+FRAC_W];
            lineSetup.minorFrac <= srcReg[DLT_LSB+FRAC_W-1:DLT_LSB];
         end else begin
            lineSetup <= '0;
            blitSetup.destX  <= destReg[X_MSB:X_LSB];
            blitSetup.destY  <= destReg[Y_MSB:Y_LSB];
            blitSetup.pixOfs <= destReg[HOFS_MSB:HOFS_LSB];
            blitSetup.rowOfs <= destReg[OCT_MSB:OCT_LSB];
            blitSetup.srcX   <= srcReg[X_MSB:X_LSB];
            blitSetup.srcY   <= srcReg[Y_MSB:Y_LSB];
         end
      end
   end

   // Clip rectangle copy for the datapath
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         clipSetup <= '0;
      end else begin
         clipSetup.left   <= clipUlReg[CLIPX_MSB:0];
         clipSetup.top    <= clipUlReg[CLIPY_MSB:CLIPY_LSB];
         clipSetup.right  <= clipLrReg[CLIPX_MSB:0];
         clipSetup.bottom <= clipLrReg[CLIPY_MSB:CLIPY_LSB];
      end
   end

   // Edges are inclusive: only strictly outside pixels are dropped
   assign insideClip = (pixX >= {1'b0, clipUlReg[CLIPX_MSB:0]})
                    && (pixY >= {2'b00, clipUlReg[CLIPY_MSB:CLIPY_LSB]})
                    && (pixX <= {1'b0, clipLrReg[CLIPX_MSB:0]})
                    && (pixY <= {2'b00, clipLrReg[CLIPY_MSB:CLIPY_LSB]});

   // In 8 bpp only the low byte takes part in the compare
   assign cmpPixel   = cmdReg[CMD_CMPDST_BIT] ? dstColor : srcColor;
   assign colorMatch = cmdReg[CMD_BPP16_BIT]
                     ? (cmpPixel == cmpReg[COLOR_MSB:0])
                     : (cmpPixel[BYTE_MSB:0] == cmpReg[BYTE_MSB:0]);

   // Per-pixel verdicts, one cycle after the pixel is presented
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         pixWrite       <= 1'b0;
         pixTransparent <= 1'b0;
      end else begin
         pixWrite       <= pixValid && insideClip;
         pixTransparent <= pixValid && colorMatch;
      end
   end

   // Checks
   a_ack_single: assert property (@(posedge clock) disable iff (!rstN)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   a_ack_answers_req: assert property (@(posedge clock) disable iff (!rstN)
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not acknowledged next cycle");

   a_start_on_write: assert property (@(posedge clock) disable iff (!rstN)
      (hitDest && cmdReg[CMD_AUTOGO_BIT]) |=> startPulse)
      else $error("dest write with auto-start gave no start pulse");

   a_start_has_cause: assert property (@(posedge clock) disable iff (!rstN)
      startPulse |-> $past(hitDest) && $past(cmdReg[CMD_AUTOGO_BIT]))
      else $error("start pulse without dest write");

   a_clip_left_top: assert property (@(posedge clock) disable iff (!rstN)
      (pixValid && ((pixX < {1'b0, clipUlReg[CLIPX_MSB:0]})
         || (pixY < {2'b00, clipUlReg[CLIPY_MSB:CLIPY_LSB]}))) |=> !pixWrite)
      else $error("pixel outside left/top clip written");

   a_clip_right_bottom: assert property (@(posedge clock) disable iff (!rstN)
      (pixValid && ((pixX > {1'b0, clipLrReg[CLIPX_MSB:0]})
         || (pixY > {2'b00, clipLrReg[CLIPY_MSB:CLIPY_LSB]}))) |=> !pixWrite)
      else $error("pixel outside right/bottom clip written");

   a_clip_inside: assert property (@(posedge clock) disable iff (!rstN)
      (pixValid && (pixX >= {1'b0, clipUlReg[CLIPX_MSB:0]})
         && (pixY >= {2'b00, clipUlReg[CLIPY_MSB:CLIPY_LSB]})
         && (pixX <= {1'b0, clipLrReg[CLIPX_MSB:0]})
         && (pixY <= {2'b00, clipLrReg[CLIPY_MSB:CLIPY_LSB]})) |=> pixWrite)
      else $error("pixel inside clip suppressed");

   // Datapath copy of the right/bottom edges trails the register by one cycle
   a_clip_copy: assert property (@(posedge clock) disable iff (!rstN)
      1'b1 |=> (clipSetup.right == $past(clipLrReg[CLIPX_MSB:0]))
         && (clipSetup.bottom == $past(clipLrReg[CLIPY_MSB:CLIPY_LSB])))
      else $error("right/bottom clip copy wrong");

   a_transp_match: assert property (@(posedge clock) disable iff (!rstN)
      (pixValid && cmdReg[CMD_BPP16_BIT]
         && ((cmdReg[CMD_CMPDST_BIT] ? dstColor : srcColor) == cmpReg[COLOR_MSB:0]))
      |=> pixTransparent)
      else $error("matching colour not flagged transparent");

   a_transp_low_byte: assert property (@(posedge clock) disable iff (!rstN)
      (pixValid && !cmdReg[CMD_BPP16_BIT]
         && ((cmdReg[CMD_CMPDST_BIT] ? dstColor[BYTE_MSB:0] : srcColor[BYTE_MSB:0])
            == cmpReg[BYTE_MSB:0]))
      |=> pixTransparent)
      else $error("matching low byte not flagged transparent");

   a_transp_miss: assert property (@(posedge clock) disable iff (!rstN)
      (pixValid && cmdReg[CMD_BPP16_BIT]
         && ((cmdReg[CMD_CMPDST_BIT] ? dstColor : srcColor) != cmpReg[COLOR_MSB:0]))
      |=> !pixTransparent)
      else $error("differing colour flagged transparent");

   a_octant_map: assert property (@(posedge clock) disable iff (!rstN)
      lineMode |-> (lineSetup.yMajor == (lineSetup.octant inside {3'h1, 3'h2, 3'h5, 3'h6}))
         && (lineSetup.negX == (lineSetup.octant inside {3'h2, 3'h3, 3'h4, 3'h5}))
         && (lineSetup.negY == lineSetup.octant[2]))
      else $error("octant decode wrong");

   a_blit_fields: assert property (@(posedge clock) disable iff (!rstN)
      !cmdReg[CMD_LINE_BIT] |=>
         (blitSetup.destX == $past(destReg[X_MSB:X_LSB]))
         && (blitSetup.destY == $past(destReg[Y_MSB:Y_LSB]))
         && (blitSetup.rowOfs == $past(destReg[OCT_MSB:OCT_LSB])) && !lineMode)
      else $error("blit origin fields wrong");

   a_line_delta: assert property (@(posedge clock) disable iff (!rstN)
      cmdReg[CMD_LINE_BIT] |=>
         ({lineSetup.minorInt, lineSetup.minorFrac} == $past(srcReg[DLT_MSB:DLT_LSB]))
         && (lineSetup.startY == $past(srcReg[X_MSB:X_LSB])) && (blitSetup == '0))
      else $error("line minor delta or start Y wrong");

endmodule
`default_nettype wire

// >>> tb/blscr_host_model.sv
// Host software model: programs the setup registers over classic Wishbone
`timescale 1ns/100ps
`default_nettype none
module blscr_host_model (
   input  wire logic        clock,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [11:0]      adr,
   output logic [3:0]       sel,
   output logic [31:0]      wdat
);
   // Bus idle at time zero
   initial begin
      {cyc, stb, we, adr, sel, wdat} = '0;
   end

   // One access; gap idles first so the slave also sees slow software
   task automatic access(input logic w, input logic [11:0] a, input logic [3:0] s,
                         input logic [31:0] d, input int gap, output logic [31:0] q);
      repeat (gap + 1) @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      @(posedge clock);
      // Request held until ack is seen at an edge; only the bench watchdog ends a hang
      while (ack !== 1'b1) begin
         @(posedge clock);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      adr <= ~a;       // Released address and data lines do not keep their last value; we and sel do
      wdat <= ~d;
   endtask
endmodule
`default_nettype wire

// >>> tb/blscr_regs_tb_top.sv
// Self-checking bench: register map, origin layouts, clip, transparency and start pulse
`timescale 1ns/100ps
`default_nettype none
module blscr_regs_tb_top;
   import blscr_pkg::*;
   logic        clock, nrst, cyc, stb, we, ack, pixValid;
   logic        pixWrite, pixTransparent, lineMode, startPulse;
   logic [3:0]  sel;
   logic [11:0] adr, pixX, pixY;
   logic [15:0] srcColor, dstColor;
   logic [31:0] wdat, rdat, q;
   logic [7:0]  yMajTab = 8'h66;
   logic [7:0]  negXTab = 8'h3c;
   logic [11:0] ofs [8] = '{12'h200, 12'h204, 12'h208, 12'h20c, 12'h210, 12'h214, 12'h218,
                            12'h21c};
   logic [31:0] msk [8] = '{32'h88000003, 32'h0, 32'hffffffff, 32'h1fffffff, 32'h0000ffff,
                            32'h03ff07ff, 32'h03ff07ff, 32'h0};
   blscr_blit_t blitSetup;
   blscr_line_t lineSetup;
   blscr_clip_t clipSetup;
   int          err_total, n_tests, pulses, strays, p;

   blscr_regs blscr_regs_i (.clock(clock), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pixValid(pixValid),
      .pixX(pixX), .pixY(pixY), .srcColor(srcColor), .dstColor(dstColor),
      .pixWrite(pixWrite), .pixTransparent(pixTransparent), .lineMode(lineMode),
      .blitSetup(blitSetup), .lineSetup(lineSetup), .clipSetup(clipSetup),
      .startPulse(startPulse));
   blscr_host_model blscr_host_model_i (.clock(clock), .ack(ack), .rdat(rdat), .cyc(cyc),
      .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Start pulses are counted; one outside an ack cycle is a stray
   always @(posedge clock) begin
      if (startPulse === 1'b1) begin
         pulses <= pulses + 1;
         strays <= strays + int'(ack !== 1'b1);
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      blscr_host_model_i.access(1'b1, a, s, d, 0, q);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      blscr_host_model_i.access(1'b0, a, 4'hf, 32'h0, 2, q);
      check(q, exp);
   endtask

   // Lets the two-cycle path from a write to the setup outputs complete
   task automatic settle;
      @(posedge clock);
      #1;
   endtask

   // One pixel; write and transparency flags show in the next cycle
   task automatic pix(input logic [11:0] x, input logic [11:0] y, input logic [15:0] s,
                      input logic [15:0] d, input logic [1:0] exp);
      @(posedge clock);
      pixValid <= 1'b1;
      pixX <= x;
      pixY <= y;
      srcColor <= s;
      dstColor <= d;
      @(posedge clock);
      pixValid <= 1'b0;
      #1;
      check({30'h0, pixWrite, pixTransparent}, {30'h0, exp});
   endtask

   task automatic results;
      $display("comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #50000;
      err_total++;
      results();
   end

   initial begin
      {nrst, pixValid, pixX, pixY, srcColor, dstColor} = '0;
      {err_total, n_tests, pulses, strays} = '0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      // Reset contents, writable masks, reserved bits and the unmapped holes
      foreach (ofs[i]) begin
         rd(ofs[i], 32'h0);
         wr(ofs[i], 32'hffffffff);
         rd(ofs[i], msk[i]);
         wr(ofs[i], 32'h0);
      end
      wr(DEST_OFS, 32'h12345678, 4'b0100);
      rd(DEST_OFS, 32'h00340000);
      $display("register map test done");
      // Block-transfer layout, every pattern pixel and row offset
      for (int i = 0; i < 8; i++) begin
         wr(DEST_OFS, {3'(7 - i), 1'b0, 12'h0a0 + 12'(i), 3'(i), 1'b0, 12'h100 + 12'(i)});
         wr(SRC_OFS, {4'h0, 12'h0b0 + 12'(i), 4'h0, 12'h300 - 12'(i)});
         settle();
         check({2'h0, blitSetup.rowOfs, blitSetup.pixOfs,
                blitSetup.destY, blitSetup.destX},
               {2'h0, 3'(7 - i), 3'(i), 12'h0a0 + 12'(i), 12'h100 + 12'(i)});
         check({8'h0, blitSetup.srcY, blitSetup.srcX},
               {8'h0, 12'h0b0 + 12'(i), 12'h300 - 12'(i)});
         check({30'h0, lineMode, |lineSetup}, 32'h0);
      end
      $display("block transfer layout test done");
      // Line-draw layout, all eight octant codes
      wr(CMD_OFS, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(DEST_OFS, {3'(i), 17'h1a5c0 + 17'(i), 12'h7f0 + 12'(i)});
         wr(SRC_OFS, {3'h0, 17'h0123f - 17'(i), 12'h055 + 12'(i)});
         settle();
         check({26'h0, lineSetup.octant, lineSetup.yMajor,
                lineSetup.negX, lineSetup.negY},
               {26'h0, 3'(i), yMajTab[i], negXTab[i], 1'(i >> 2)});
         check({3'h0, lineSetup.majorInt,
                lineSetup.majorFrac, lineSetup.startX},
               {3'h0, 17'h1a5c0 + 17'(i), 12'h7f0 + 12'(i)});
         check({3'h0, lineSetup.minorInt,
                lineSetup.minorFrac, lineSetup.startY},
               {3'h0, 17'h0123f - 17'(i), 12'h055 + 12'(i)});
         check({30'h0, lineMode, |blitSetup}, 32'h2);
      end
      $display("line draw layout test done");
      // Clip rectangle 10..30 by 20..40, edges and one past each edge
      wr(CMD_OFS, 32'h2);
      wr(CMP_OFS, 32'h1234);
      wr(CLIPUL_OFS, {6'h0, 10'h014, 5'h0, 11'h00a});
      wr(CLIPLR_OFS, {6'h0, 10'h028, 5'h0, 11'h01e});
      settle();
      check({11'h0, clipSetup.top, clipSetup.left}, {11'h0, 10'h014, 11'h00a});
      check({11'h0, clipSetup.bottom, clipSetup.right}, {11'h0, 10'h028, 11'h01e});
      pix(12'h00a, 12'h014, 16'h0, 16'h0, 2'b10);
      pix(12'h009, 12'h014, 16'h0, 16'h0, 2'b00);
      pix(12'h00a, 12'h013, 16'h0, 16'h0, 2'b00);
      pix(12'h01e, 12'h028, 16'h0, 16'h0, 2'b10);
      pix(12'h01f, 12'h028, 16'h0, 16'h0, 2'b00);
      pix(12'h01e, 12'h029, 16'h0, 16'h0, 2'b00);
      $display("clip test done");
      // Compare colour against source at 16 and 8 bpp, then against destination
      pix(12'h00a, 12'h014, 16'h1234, 16'h0, 2'b11);
      pix(12'h00a, 12'h014, 16'h1235, 16'h1234, 2'b10);
      wr(CMD_OFS, 32'h0);
      settle();
      pix(12'h00a, 12'h014, 16'hff34, 16'h0, 2'b11);
      pix(12'h00a, 12'h014, 16'h1235, 16'h0, 2'b10);
      wr(CMD_OFS, 32'h80000002);
      settle();
      pix(12'h00a, 12'h014, 16'h0, 16'h1234, 2'b11);
      pix(12'h00a, 12'h014, 16'h1234, 16'h1233, 2'b10);
      $display("transparency test done");
      // Start only on a destination write with the start option set
      p = pulses;
      wr(CMD_OFS, 32'h08000000);
      wr(DEST_OFS, 32'h1);
      wr(SRC_OFS, 32'h1);
      wr(CMD_OFS, 32'h0);
      wr(DEST_OFS, 32'h2);
      settle();
      check(32'(pulses - p), 32'h1);
      check(32'(strays), 32'h0);
      $display("start test done");
      // Reset in mid-run clears the registers and the datapath copies
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      rd(DEST_OFS, 32'h0);
      rd(CLIPUL_OFS, 32'h0);
      check({11'h0, clipSetup.top, clipSetup.left}, 32'h0);
      $display("mid-run reset test done");
      results();
   end
endmodule
`default_nettype wire
